// file: dar_checker.sv
// concurrent checks on the readout ports
`timescale 1ns/10ps
module dar_checker (
  // clock and reset
  input wire logic               aclk,
  input wire logic               aresetn,
  // register bus
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire logic [1:0]         s_axi_bresp,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  input wire logic [31:0]        s_axi_rdata,
  // host pins and straps
  input wire logic               conversion_start_n,
  input wire logic               shift_clock,
  input wire logic               mode_strap_high,
  input wire logic               mode_strap_low,
  input wire logic               ref_buffer_enable,
  input wire logic               echo_clock_n_sense,
  // outputs under check
  input wire dar_pkg::dar_pair_s ch1_serial_out,
  input wire dar_pkg::dar_pair_s ch2_serial_out,
  input wire dar_pkg::dar_pair_s echo_clock,
  input wire logic               sample_hold,
  input wire logic               ch1_reference_output,
  input wire logic               ch2_reference_output,
  input wire logic               low_power_lvds
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // straps are synchronised, so judge them only once settled
  sequence s_cmos;
    (!mode_strap_high && !mode_strap_low)[*6];
  endsequence
  sequence s_start;
    $fell(conversion_start_n) && !sample_hold;
  endsequence

  // answers come exactly one cycle after the taking edge
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write response missing");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read data missing");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  // conversion start, data and echo drive, mode and reference straps
  a_start_holds: assert property (s_start |-> ##[1:4] sample_hold)
    else $error("no hold after start");
  a_start_drives: assert property (s_start |-> ##[2:6]
    (ch1_serial_out.p_oe && ch2_serial_out.p_oe))
    else $error("data not driven after start");
  a_idle_release: assert property (conversion_start_n[*6] |->
    !ch1_serial_out.p_oe && !ch2_serial_out.p_oe)
    else $error("data driven while start high");
  a_data_diff: assert property (ch1_serial_out.n_oe |->
    ch1_serial_out.n == !ch1_serial_out.p && ch1_serial_out.p_oe)
    else $error("data legs not complementary");
  a_echo_diff: assert property (echo_clock.n_oe |->
    echo_clock.n == !echo_clock.p) else $error("echo legs not complementary");
  a_cmos_single: assert property (s_cmos |->
    !ch1_serial_out.n_oe && !ch2_serial_out.n_oe && !echo_clock.n_oe &&
    !low_power_lvds)
    else $error("negative leg driven in cmos");
  a_echo_off: assert property (s_cmos and echo_clock_n_sense[*6] |->
    !echo_clock.p_oe) else $error("echo driven while disabled");
  a_echo_follow: assert property ($rose(shift_clock) &&
    echo_clock.p_oe |-> ##[1:5] $rose(echo_clock.p))
    else $error("echo does not follow clock");
  a_low_power: assert property (
    (!mode_strap_high && mode_strap_low)[*6] |-> low_power_lvds)
    else $error("low power mode not selected");
  a_ref_follow: assert property ($stable(ref_buffer_enable)[*6] |->
    ch1_reference_output == ref_buffer_enable &&
    ch2_reference_output == ref_buffer_enable)
    else $error("reference buffers do not follow strap");
endmodule

bind dar_top dar_checker i_chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .conversion_start_n, .shift_clock, .mode_strap_high, .mode_strap_low,
  .ref_buffer_enable, .echo_clock_n_sense, .ch1_serial_out, .ch2_serial_out,
  .echo_clock, .sample_hold, .ch1_reference_output, .ch2_reference_output,
  .low_power_lvds
);

// file: dar_fifo2.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
module dar_fifo2 #(
  parameter int W = 26
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data,
  // occupancy
  output logic [1:0]        fill
);

  logic [W-1:0] mem [2];
  logic [W-1:0] next_mem [2];
  logic         wr_ptr;
  logic         next_wr_ptr;
  logic         rd_ptr;
  logic         next_rd_ptr;
  logic [1:0]   count;
  logic [1:0]   next_count;
  logic         push;
  logic         pop;

  // full and empty come straight from the count so they never lie
  assign in_ready  = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data  = mem[rd_ptr];
  assign fill      = count;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // next pointers, count and storage
  always_comb begin
    next_mem    = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push) begin
      next_mem[wr_ptr] = in_data;
      next_wr_ptr      = ~wr_ptr;
    end
    if (pop) begin
      next_rd_ptr = ~rd_ptr;
    end
    if (push && !pop) begin
      next_count = count + 2'h1;
    end else if (pop && !push) begin
      next_count = count - 2'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
      mem[0] <= '0;
      mem[1] <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
      mem    <= next_mem;
    end
  end

endmodule

// file: dar_host.sv
// host model: makes conversion starts and shift clock, captures data
`timescale 1ns/10ps
module dar_host (
  // clock
  input wire logic               aclk,
  // pins towards the converter
  output logic                   conversion_start_n,
  output logic                   shift_clock,
  // serial data back
  input wire dar_pkg::dar_pair_s ch1_serial_out,
  input wire dar_pkg::dar_pair_s ch2_serial_out
);
  // shift clock stands low outside frames
  initial begin
    conversion_start_n = 1'h1;
    shift_clock        = 1'h0;
  end

  // one frame; h is the sck high time in aclk cycles, low time h + 4, 2 or more
  task automatic frame(input int h, output logic [12:0] c1,
                       output logic [12:0] c2);
    @(posedge aclk);
    conversion_start_n <= 1'h0; // periodic start from clean clock
    repeat (8) @(posedge aclk);
    for (int i = 12; i >= 0; i--) begin
      c1[i] = ch1_serial_out.p; // own clock capture
      c2[i] = ch2_serial_out.p;
      shift_clock <= 1'h1; // single wire drive of the clock
      repeat (h) @(posedge aclk);
      shift_clock <= 1'h0;
      repeat (h + 4) @(posedge aclk);
    end
    conversion_start_n <= 1'h1;
    repeat (8) @(posedge aclk);
  endtask
endmodule

// file: dar_pkg.sv
// types shared by the dual channel serial readout
package dar_pkg;

  typedef enum logic [1:0] {
    DAR_MODE_CMOS,
    DAR_MODE_LVDS,
    DAR_MODE_LP_LVDS
  } dar_mode_e;

  typedef enum logic [1:0] {
    DAR_ACQUIRE,
    DAR_SHIFT,
    DAR_DONE
  } dar_state_e;

  // one converted pair, as the core hands it to the serialiser
  typedef struct packed {
    logic [12:0] ch2;
    logic [12:0] ch1;
  } dar_sample_s;

  // one differential output pair with its drive enables
  typedef struct packed {
    logic p;
    logic p_oe;
    logic n;
    logic n_oe;
  } dar_pair_s;

endpackage

// file: dar_regs.svh
// register map, field positions, reset values and counts of the readout
// Behaviour
// R1: falling conversion start holds and starts conversion
// R2: both channels shift MSB first on falling clock
// R3: CMOS mode drives data on positive leg
// R4: LVDS mode drives data differentially
// R5: echo clock follows shift clock, matched to data
// R6: CMOS echo clock on positive leg only
// R7: LVDS echo clock driven differentially
// R8: CMOS echo off when negative leg tied high
// R9: host may latch with own clock
// R10: host drives shift clock per signalling mode; the host model drives one single-ended wire in every mode
// R11: mode strap low CMOS, high LVDS, float low-power
// R12: conversion start same in every mode
// R13: host drives conversion start from clean clock
// R14: low reference strap disables both reference buffers
// R15: result is 13-bit two's complement code
// R16: host shift clock up to 105 MHz
// R17: host gives thirteen falling edges per conversion
// R18: data outputs released while conversion start high
`ifndef DAR_REGS_SVH
`define DAR_REGS_SVH

`define DAR_CODE_W      13
`define DAR_BITS        4'hD
`define DAR_CNT_W       16

`define DAR_OFS_CTRL    4'h0
`define DAR_OFS_STATUS  4'h4
`define DAR_OFS_SAMPLE  4'h8
`define DAR_OFS_COUNT   4'hC

`define DAR_CTRL_EN     0
`define DAR_CTRL_RST    1'h1

`define DAR_SMP_CH1_LSB 0
`define DAR_SMP_CH2_LSB 16

`define DAR_ST_MODE_LSB 0
`define DAR_ST_REFEN    2
`define DAR_ST_ECHOOFF  3
`define DAR_ST_STATE    4
`define DAR_ST_BITS_LSB 8
`define DAR_ST_FILL_LSB 12

`define DAR_RESP_OKAY   2'h0
`define DAR_RESP_SLVERR 2'h2

`endif

// file: dar_top.sv
// conversion control and dual serial readout with AXI4-Lite registers
`timescale 1ns/10ps
`include "dar_regs.svh"
module dar_top (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write address and data
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [3:0]        s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  // axi4-lite write response
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  // axi4-lite read
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [3:0]        s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  // host pins and straps, asynchronous to aclk
  input  wire logic              conversion_start_n,
  input  wire logic              shift_clock,
  input  wire logic              mode_strap_high,
  input  wire logic              mode_strap_low,
  input  wire logic              ref_buffer_enable,
  input  wire logic              echo_clock_n_sense,
  // serial outputs and echo clock
  output dar_pkg::dar_pair_s     ch1_serial_out,
  output dar_pkg::dar_pair_s     ch2_serial_out,
  output dar_pkg::dar_pair_s     echo_clock,
  // analog side controls
  output logic                   sample_hold,
  output logic                   ch1_reference_output,
  output logic                   ch2_reference_output,
  output logic                   low_power_lvds
);
  import dar_pkg::*;

  // every pin passes two flops before anything looks at it
  logic [5:0] pin_meta;
  logic [5:0] pin_sync;
  logic       cnv_n;
  logic       sck;
  logic       strap_hi;
  logic       strap_lo;
  logic       refen;
  logic       echo_n_hi;
  logic       cnv_prev;
  logic       sck_prev;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta <= 6'h01;
      pin_sync <= 6'h01;
      cnv_prev <= 1'b1;
      sck_prev <= 1'b0;
    end else begin
      pin_meta <= {echo_clock_n_sense, ref_buffer_enable, mode_strap_low,
                   mode_strap_high, shift_clock, conversion_start_n};
      pin_sync <= pin_meta;
      cnv_prev <= pin_sync[0];
      sck_prev <= pin_sync[1];
    end
  end

  assign cnv_n     = pin_sync[0];
  assign sck       = pin_sync[1];
  assign strap_hi  = pin_sync[2];
  assign strap_lo  = pin_sync[3];
  assign refen     = pin_sync[4];
  assign echo_n_hi = pin_sync[5];

  // the start edge is decoded identically in every signalling mode
  logic cnv_fall;
  logic cnv_rise;
  logic sck_fall;
  assign cnv_fall = cnv_prev && !cnv_n;  // see R1 see R12
  assign cnv_rise = !cnv_prev && cnv_n;
  assign sck_fall = sck_prev && !sck;

  // strap decode: the sense pins carry the strap through a weak pull
  // each way, so agreement means tied and disagreement means floating
  dar_mode_e mode;
  assign mode = (strap_hi != strap_lo) ? DAR_MODE_LP_LVDS :  // see R11
                (strap_hi ? DAR_MODE_LVDS : DAR_MODE_CMOS);

  // register bus: control, status, sample and conversion count
  logic              ctrl_en;
  logic              next_ctrl_en;
  logic              bvalid;
  logic              next_bvalid;
  logic [1:0]        bresp;
  logic [1:0]        next_bresp;
  logic              rvalid;
  logic              next_rvalid;
  logic [31:0]       rdata;
  logic [31:0]       next_rdata;
  logic [1:0]        rresp;
  logic [1:0]        next_rresp;
  logic              wr_go;
  logic              wr_sample;
  logic              rd_go;
  logic [31:0]       wmask;
  logic [31:0]       wword;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic              fifo_pop;
  dar_sample_s       fifo_out;
  dar_sample_s       fifo_in;
  logic [1:0]        fifo_fill;
  logic [`DAR_CNT_W-1:0] conv_count;
  logic [`DAR_CNT_W-1:0] next_conv_count;
  dar_state_e        state;
  dar_state_e        next_state;
  logic [3:0]        bits;
  logic [3:0]        next_bits;
  logic              echo_off;

  // both halves of a write must be present; a sample write also waits
  // for room in the buffer, which is how a stalled reader backs up
  assign wr_sample = (s_axi_awaddr == `DAR_OFS_SAMPLE);
  assign wr_go     = s_axi_awvalid && s_axi_wvalid && !bvalid &&
                     (!wr_sample || fifo_in_ready);
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign rd_go         = s_axi_arvalid && !rvalid;
  assign s_axi_arready = rd_go;
  assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                  {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  assign wword = s_axi_wdata & wmask;
  assign fifo_in.ch1 = wword[`DAR_SMP_CH1_LSB +: `DAR_CODE_W];
  assign fifo_in.ch2 = wword[`DAR_SMP_CH2_LSB +: `DAR_CODE_W];

  // bus next values
  always_comb begin
    next_ctrl_en = ctrl_en;
    next_bvalid  = bvalid && !s_axi_bready;
    next_bresp   = bresp;
    next_rvalid  = rvalid && !s_axi_rready;
    next_rdata   = rdata;
    next_rresp   = rresp;
    if (wr_go) begin
      next_bvalid = 1'b1;
      next_bresp  = `DAR_RESP_OKAY;
      unique case (s_axi_awaddr)
        `DAR_OFS_CTRL: begin
          if (s_axi_wstrb[0]) begin
            next_ctrl_en = s_axi_wdata[`DAR_CTRL_EN];
          end
        end
        `DAR_OFS_SAMPLE, `DAR_OFS_STATUS, `DAR_OFS_COUNT: begin
        end
        default: begin
          next_bresp = `DAR_RESP_SLVERR;
        end
      endcase
    end
    if (rd_go) begin
      next_rvalid = 1'b1;
      next_rresp  = `DAR_RESP_OKAY;
      next_rdata  = 32'h0000_0000;
      unique case (s_axi_araddr)
        `DAR_OFS_CTRL: begin
          next_rdata[`DAR_CTRL_EN] = ctrl_en;
        end
        `DAR_OFS_STATUS: begin
          next_rdata[`DAR_ST_MODE_LSB +: 2]  = mode;
          next_rdata[`DAR_ST_REFEN]          = refen;
          next_rdata[`DAR_ST_ECHOOFF]        = echo_off;
          next_rdata[`DAR_ST_STATE +: 2]     = state;
          next_rdata[`DAR_ST_BITS_LSB +: 4]  = bits;
          next_rdata[`DAR_ST_FILL_LSB +: 2]  = fifo_fill;
        end
        `DAR_OFS_SAMPLE: begin
        end
        `DAR_OFS_COUNT: begin
          next_rdata[`DAR_CNT_W-1:0] = conv_count;
        end
        default: begin
          next_rresp = `DAR_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_en <= `DAR_CTRL_RST;
      bvalid  <= 1'b0;
      bresp   <= `DAR_RESP_OKAY;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `DAR_RESP_OKAY;
    end else begin
      ctrl_en <= next_ctrl_en;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
    end
  end

  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp  = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata  = rdata;
  assign s_axi_rresp  = rresp;

  // results wait here until a conversion start claims them
  assign fifo_pop = cnv_fall && ctrl_en;
  dar_fifo2 #(.W ($bits(dar_sample_s))) u_buf (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (wr_go && wr_sample),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out),
    .fill      (fifo_fill)
  );

  // conversion sequencer and the two shift registers
  logic [`DAR_CODE_W-1:0] sh1;
  logic [`DAR_CODE_W-1:0] next_sh1;
  logic [`DAR_CODE_W-1:0] sh2;
  logic [`DAR_CODE_W-1:0] next_sh2;
  dar_sample_s            last;
  dar_sample_s            next_last;

  always_comb begin
    next_state      = state;
    next_bits       = bits;
    next_sh1        = sh1;
    next_sh2        = sh2;
    next_last       = last;
    next_conv_count = conv_count;
    if (cnv_rise) begin
      next_state = DAR_ACQUIRE;  // see R18
    end else if (fifo_pop) begin
      // an empty buffer repeats the previous code rather than stall
      if (fifo_out_valid) begin
        next_last = fifo_out;
      end
      next_sh1        = fifo_out_valid ? fifo_out.ch1 : last.ch1;  // see R15
      next_sh2        = fifo_out_valid ? fifo_out.ch2 : last.ch2;
      next_bits       = 4'h0;
      next_state      = DAR_SHIFT;  // see R1
      next_conv_count = conv_count + 16'h0001;
    end else if (state == DAR_SHIFT && sck_fall) begin
      next_sh1  = {sh1[`DAR_CODE_W-2:0], 1'b0};  // see R2
      next_sh2  = {sh2[`DAR_CODE_W-2:0], 1'b0};  // see R2
      next_bits = bits + 4'h1;
      if (bits + 4'h1 == `DAR_BITS) begin
        next_state = DAR_DONE;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state      <= DAR_ACQUIRE;
      bits       <= 4'h0;
      sh1        <= '0;
      sh2        <= '0;
      last       <= '0;
      conv_count <= '0;
    end else begin
      state      <= next_state;
      bits       <= next_bits;
      sh1        <= next_sh1;
      sh2        <= next_sh2;
      last       <= next_last;
      conv_count <= next_conv_count;
    end
  end

  // pin drivers; data and echo go through one flop stage each so their
  // skew to one another stays equal
  logic        drive;
  dar_pair_s   d1;
  dar_pair_s   next_d1;
  dar_pair_s   d2;
  dar_pair_s   next_d2;
  dar_pair_s   ec;
  dar_pair_s   next_ec;
  logic        lvds;

  assign drive    = (state != DAR_ACQUIRE) && !cnv_n;  // see R18
  assign lvds     = (mode != DAR_MODE_CMOS);
  assign echo_off = !lvds && echo_n_hi;  // see R8

  always_comb begin
    next_d1.p    = sh1[`DAR_CODE_W-1];
    next_d1.n    = ~sh1[`DAR_CODE_W-1];
    next_d1.p_oe = drive;  // see R3 see R4
    next_d1.n_oe = drive && lvds;  // see R3 see R4
    next_d2.p    = sh2[`DAR_CODE_W-1];
    next_d2.n    = ~sh2[`DAR_CODE_W-1];
    next_d2.p_oe = drive;  // see R3 see R4
    next_d2.n_oe = drive && lvds;  // see R3 see R4
    next_ec.p    = sck;  // see R5
    next_ec.n    = ~sck;
    next_ec.p_oe = !echo_off;  // see R6 see R8
    next_ec.n_oe = lvds;  // see R6 see R7
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      d1   <= '0;
      d2   <= '0;
      ec   <= '0;
    end else begin
      d1   <= next_d1;
      d2   <= next_d2;
      ec   <= next_ec;
    end
  end

  assign ch1_serial_out = d1;
  assign ch2_serial_out = d2;
  assign echo_clock     = ec;
  assign low_power_lvds = (mode == DAR_MODE_LP_LVDS);

  // hold while converting or shifting, track the input while acquiring
  assign sample_hold          = (state != DAR_ACQUIRE);  // see R1
  assign ch1_reference_output = refen;  // see R14
  assign ch2_reference_output = refen;  // see R14

endmodule

// file: dar_top_bench.sv
// self-checking bench for the dual readout
`timescale 1ns/10ps
module dar_top_bench;
  logic              aclk;
  logic              aresetn;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic              s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic              s_axi_rready;
  logic [3:0]        s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0]       s_axi_wdata, s_axi_rdata;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic              conversion_start_n, shift_clock;
  logic              mode_strap_high, mode_strap_low;
  logic              ref_buffer_enable, echo_clock_n_sense;
  dar_pkg::dar_pair_s ch1_serial_out, ch2_serial_out, echo_clock;
  logic              sample_hold, low_power_lvds;
  logic              ch1_reference_output, ch2_reference_output;
  int                n_fail, n_tests, cyc;

  dar_top i_dut (.*);
  dar_host i_host (.aclk, .conversion_start_n, .shift_clock,
                   .ch1_serial_out, .ch2_serial_out);

  // 100 MHz clock
  initial begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // hang guard, far beyond the fewer than a thousand cycles the run needs
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // write: address and data offered together, each released when taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic ta, tw, da, dw;
    da = 1'h0;
    dw = 1'h0;
    @(posedge aclk);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    do begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      da |= ta;
      dw |= tw;
    end while (!(da && dw));
    do @(negedge aclk); while (!s_axi_bvalid);
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    @(posedge aclk);
    s_axi_bready <= 1'h0;
  endtask

  task automatic rd(input string nm, input logic [3:0] a,
                    input logic [31:0] m, e, input logic [1:0] er);
    logic t;
    @(posedge aclk);
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    s_axi_araddr <= a;
    do begin
      @(negedge aclk);
      t = s_axi_arready;
      @(posedge aclk);
    end while (!t);
    s_axi_arvalid <= 1'h0;
    do @(negedge aclk); while (!s_axi_rvalid);
    chk(nm, e & m, s_axi_rdata & m);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    @(posedge aclk);
    s_axi_rready <= 1'h0;
  endtask

  // one conversion frame, both channels compared
  task automatic conv(input int h, input logic [12:0] e1, e2);
    logic [12:0] g1, g2;
    i_host.frame(h, g1, g2);
    chk("ch1 code", {19'h0, e1}, {19'h0, g1});
    chk("ch2 code", {19'h0, e2}, {19'h0, g2});
  endtask

  task automatic straps(input logic [3:0] s);
    @(posedge aclk);
    {mode_strap_high, mode_strap_low} <= s[3:2];
    ref_buffer_enable <= s[1];
    echo_clock_n_sense <= s[0];
    repeat (10) @(posedge aclk);
  endtask

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 10'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    {mode_strap_high, mode_strap_low, ref_buffer_enable} = 3'h7;
    echo_clock_n_sense = 1'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (3) @(posedge aclk);
    // reset values, read-only and unmapped places
    rd("ctrl", 4'h0, 32'h1, 32'h1, 2'h0);
    rd("count", 4'hC, 32'hFFFF, 32'h0, 2'h0);
    rd("status", 4'h4, 32'h3037, 32'h5, 2'h0);
    rd("unmapped", 4'h2, 32'hFFFFFFFF, 32'h0, 2'h2);
    wr(4'h4, 32'hFFFF, 2'h0);
    wr(4'h7, 32'h0, 2'h2);
    // enable bit cleared and set again, read back each time
    wr(4'h0, 32'h0, 2'h0);
    rd("ctrl off", 4'h0, 32'h1, 32'h0, 2'h0);
    wr(4'h0, 32'h1, 2'h0);
    rd("ctrl on", 4'h0, 32'h1, 32'h1, 2'h0);
    // a sign-boundary pair and an alternating-bit pair queued, then an empty buffer
    wr(4'h8, 32'h0FFF1000, 2'h0);
    wr(4'h8, 32'h0AAA1555, 2'h0);
    rd("fill", 4'h4, 32'h3000, 32'h2000, 2'h0);
    conv(2, 13'h1000, 13'h0FFF);
    conv(5, 13'h1555, 13'h0AAA);
    conv(2, 13'h1555, 13'h0AAA);
    rd("count", 4'hC, 32'hFFFF, 32'h3, 2'h0);
    $display("test lvds done");
    // single-ended mode, echo off, reference buffers off
    straps(4'h1);
    chk("ref outputs", 32'h0, {30'h0, ch1_reference_output,
        ch2_reference_output});
    rd("status", 4'h4, 32'h300F, 32'h8, 2'h0);
    wr(4'h8, 32'h00001FFF, 2'h0);
    conv(3, 13'h1FFF, 13'h0000);
    $display("test cmos done");
    // floating strap: low-power differential mode
    straps(4'h6);
    chk("low power", 32'h1, {31'h0, low_power_lvds});
    rd("status", 4'h4, 32'h300F, 32'h6, 2'h0);
    // top byte strobed off, so bits 12:8 of ch2 never land
    s_axi_wstrb <= 4'h7;
    wr(4'h8, 32'h10F00F0F, 2'h0);
    conv(2, 13'h0F0F, 13'h00F0);
    $display("test low power done");
    final_report();
  end
endmodule
